// >>> lsr_pkg.sv
`default_nettype none
package lsr_pkg;

    // Bus shape.
    localparam int ADDR_W = 18;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;
    localparam int IDX_W = 16;

    // Register indices; the byte address is four times the index.
    localparam logic [IDX_W-1:0] IDX_R7_SLEEP = 16'h407c;
    localparam logic [IDX_W-1:0] IDX_R8_CTRL = 16'h407d;
    localparam logic [IDX_W-1:0] IDX_R8_ON = 16'h407e;
    localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 16'h4090;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 16'h4091;

    // Writable bits and reset values of the three configuration registers.
    localparam logic [REG_W-1:0] MASK_R7_SLEEP = 16'he11f;
    localparam logic [REG_W-1:0] MASK_R8_CTRL = 16'hdfc0;
    localparam logic [REG_W-1:0] MASK_R8_ON = 16'he11f;
    localparam logic [REG_W-1:0] RST_R7_SLEEP = 16'h0100;
    localparam logic [REG_W-1:0] RST_R8_CTRL = 16'h0200;
    localparam logic [REG_W-1:0] RST_R8_ON = 16'h0000;

    // Field positions.
    localparam int SLOT_MSB = 15;
    localparam int SLOT_LSB = 13;
    localparam int MODE_BIT = 8;
    localparam int VSEL_MSB = 4;
    localparam int ACT_MSB = 15;
    localparam int ACT_LSB = 14;
    localparam int SRC_MSB = 12;
    localparam int SRC_LSB = 11;
    localparam int HVSEL_BIT = 10;
    localparam int HMODE_MSB = 9;
    localparam int HMODE_LSB = 8;
    localparam int FLT_BIT = 7;
    localparam int SWI_BIT = 6;

    // Field codes.
    localparam logic [1:0] ACT_SHUT = 2'h1;
    localparam logic [1:0] ACT_RESET = 2'h2;
    localparam logic [1:0] SRC_CTL1 = 2'h1;
    localparam logic [1:0] SRC_CTL2 = 2'h2;
    localparam logic [1:0] SRC_EITHER = 2'h3;
    localparam logic [1:0] HMODE_OFF = 2'h1;
    localparam logic [1:0] HMODE_FOLLOW = 2'h3;
    localparam logic [2:0] SLOT_FIRST = 3'h1;
    localparam logic [2:0] SLOT_LAST = 3'h5;
    localparam logic [2:0] SLOT_T3 = 3'h3;
    localparam logic [2:0] SLP_CODE_T3 = 3'h6;
    localparam logic [2:0] SLP_CODE_T1 = 3'h7;
    localparam logic [2:0] ON_CODE_HW1 = 3'h6;
    localparam logic [2:0] ON_CODE_HW2 = 3'h7;

    // Voltage code mapping in millivolts.
    localparam logic [11:0] MV_BASE = 12'h3e8;
    localparam logic [11:0] MV_FINE = 12'h032;
    localparam logic [11:0] MV_KNEE = 12'h6a4;
    localparam logic [11:0] MV_COARSE = 12'h064;
    localparam logic [4:0] CODE_KNEE = 5'h0d;

    // Interrupt status bits.
    localparam int IRQ_W = 2;
    localparam int IRQ_UV = 0;
    localparam int IRQ_TRIP = 1;

    typedef enum logic [1:0] {R8_OFF, R8_ON, R8_TRIP} lsr_r8_state_e;

    // Timeslot in which a sleep slot code acts.
    function automatic logic [2:0] lsr_sleep_slot(input logic [2:0] code);
        if (code == 3'h0)
            return SLOT_LAST;
        else if (code == SLP_CODE_T3)
            return SLOT_T3;
        else if (code == SLP_CODE_T1)
            return SLOT_FIRST;
        else
            return 3'(SLOT_LAST + SLOT_FIRST - code);
    endfunction : lsr_sleep_slot

    // True for the codes that name timeslots one to five.
    function automatic logic lsr_in_slots(input logic [2:0] code);
        return (code >= SLOT_FIRST) && (code <= SLOT_LAST);
    endfunction : lsr_in_slots

endpackage : lsr_pkg
`default_nettype wire

// >>> lsr_volt_map.sv
`timescale 1ns/100ps
`default_nettype none
module lsr_volt_map
    import lsr_pkg::*;
(
    // Clock for the checks only.
    input wire logic clk_sys,
    input wire logic nrst,
    // Code in, millivolts out.
    input wire logic [4:0] code,
    output logic [11:0] mv
);

    // Fine steps below the knee, coarse steps from it upward.
    always_comb
    begin
        if (code < CODE_KNEE)
            mv = 12'(MV_BASE + MV_FINE * 12'(code));
        else
            mv = 12'(MV_KNEE + MV_COARSE * 12'(code - CODE_KNEE));
    end

    chk_volt_map_knee:
        assert property (@(posedge clk_sys) disable iff (!nrst)
            (code == CODE_KNEE) |-> (mv == 12'h6a4))
        else $error("Knee code does not give 1.70V.");

    chk_volt_map_ends:
        assert property (@(posedge clk_sys) disable iff (!nrst)
            ((code == 5'h0c) |-> (mv == 12'h640)) and ((code == 5'h1f) |-> (mv == 12'hdac)))
        else $error("Voltage code end points are wrong.");

endmodule : lsr_volt_map
`default_nettype wire

// >>> lsr_apb_slave.sv
`timescale 1ns/100ps
`default_nettype none
module lsr_apb_slave
    import lsr_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic nrst,
    // APB.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Register file side.
    output logic [IDX_W-1:0] regIdx,
    input wire logic [REG_W-1:0] rdData,
    input wire logic rdHit,
    output logic wrStb,
    output logic rdStb
);

    logic hitQ;
    logic accStb;

    // The index is decoded in the setup cycle; misaligned words miss.
    assign regIdx = paddr[ADDR_W-1:2];
    assign accStb = psel && penable;

    // Read data is caught at setup, so the access phase ends at once.
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            prdata <= '0;
            hitQ <= 1'b0;
        end
        else if (psel && !penable)
        begin
            hitQ <= rdHit && (paddr[1:0] == 2'h0);
            prdata <= (rdHit && !pwrite) ? {16'h0000, rdData} : '0;
        end
    end

    assign pready = 1'b1;
    assign pslverr = accStb && !hitQ;
    assign wrStb = accStb && pwrite && hitQ;
    assign rdStb = accStb && !pwrite && hitQ;

endmodule : lsr_apb_slave
`default_nettype wire

// >>> lsr_regs.sv
`timescale 1ns/100ps
`default_nettype none
module lsr_regs
    import lsr_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic nrst,
    // APB.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sequencer, same clock.
    input wire logic seqStartup,
    input wire logic seqSleep,
    input wire logic seqSlotStb,
    input wire logic [2:0] seqSlotNum,
    input wire logic r7HwEnAssign,
    input wire logic r8SleepOff,
    input wire logic [4:0] r8SleepVoltCode,
    // Pins and analog flags, asynchronous.
    input wire logic hwEnable1,
    input wire logic hwEnable2,
    input wire logic hwControl1,
    input wire logic hwControl2,
    input wire logic r8Undervolt,
    // Regulator seven sleep controls.
    output logic r7SleepApply,
    output logic r7SleepOff,
    output logic r7SleepLowPower,
    output logic [11:0] r7SleepMv,
    // Regulator eight controls.
    output logic r8Enable,
    output logic r8LowPower,
    output logic r8Discharge,
    output logic r8SwitchMode,
    output logic [11:0] r8VoltMv,
    // System.
    output logic devResetReq,
    output logic irq
);

    logic [REG_W-1:0] r7SleepQ, r8CtrlQ, r8OnQ, rdData;
    logic [IRQ_W-1:0] irqStatQ, irqMaskQ;
    logic [IDX_W-1:0] regIdx;
    logic rdHit, wrStb, rdStb;
    logic [4:0] syncAQ, syncBQ, r8CodeSel;
    logic uvPrevQ, startPrevQ, uvEdge, startRise;
    lsr_r8_state_e r8StateQ, r8StateD;
    logic hwActive, hwEnPin, slotHitR7;
    logic [11:0] r7MvComb, r8MvComb;
    logic [2:0] r7Slot, r8OnSlot;
    logic [1:0] uvAction, hwMode, hwSrc;

    // Field views.
    assign r7Slot = r7SleepQ[SLOT_MSB:SLOT_LSB];
    assign r8OnSlot = r8OnQ[SLOT_MSB:SLOT_LSB];
    assign uvAction = r8CtrlQ[ACT_MSB:ACT_LSB];
    assign hwMode = r8CtrlQ[HMODE_MSB:HMODE_LSB];
    assign hwSrc = r8CtrlQ[SRC_MSB:SRC_LSB];

    lsr_apb_slave u_apb (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .regIdx(regIdx),
        .rdData(rdData),
        .rdHit(rdHit),
        .wrStb(wrStb),
        .rdStb(rdStb)
    );

    // Read mux; unmapped indices miss and read zero.
    always_comb
    begin
        rdHit = 1'b1;
        unique case (regIdx)
            IDX_R7_SLEEP: rdData = r7SleepQ;
            IDX_R8_CTRL: rdData = r8CtrlQ;
            IDX_R8_ON: rdData = r8OnQ;
            IDX_IRQ_STAT: rdData = 16'(irqStatQ);
            IDX_IRQ_MASK: rdData = 16'(irqMaskQ);
            default:
            begin
                rdData = '0;
                rdHit = 1'b0;
            end
        endcase
    end

    // Configuration registers; the masks keep unassigned bits at zero.
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            r7SleepQ <= RST_R7_SLEEP;
            r8CtrlQ <= RST_R8_CTRL;
            r8OnQ <= RST_R8_ON;
            irqMaskQ <= '0;
        end
        else if (wrStb)
        begin
            if (regIdx == IDX_R7_SLEEP)
                r7SleepQ <= pwdata[REG_W-1:0] & MASK_R7_SLEEP;
            if (regIdx == IDX_R8_CTRL)
                r8CtrlQ <= pwdata[REG_W-1:0] & MASK_R8_CTRL;
            if (regIdx == IDX_R8_ON)
                r8OnQ <= pwdata[REG_W-1:0] & MASK_R8_ON;
            if (regIdx == IDX_IRQ_MASK)
                irqMaskQ <= pwdata[IRQ_W-1:0];
        end
    end

    // Pins and the analog flag cross in through two flip-flops.
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            syncAQ <= '0;
            syncBQ <= '0;
            uvPrevQ <= 1'b0;
            startPrevQ <= 1'b0;
        end
        else
        begin
            syncAQ <= {r8Undervolt, hwControl2, hwControl1, hwEnable2, hwEnable1};
            syncBQ <= syncAQ;
            uvPrevQ <= syncBQ[4];
            startPrevQ <= seqStartup;
        end
    end

    assign uvEdge = syncBQ[4] && !uvPrevQ;
    assign startRise = seqStartup && !startPrevQ;

    // Selected hardware control input.
    always_comb
    begin
        unique case (hwSrc)
            SRC_CTL1: hwActive = syncBQ[2];
            SRC_CTL2: hwActive = syncBQ[3];
            SRC_EITHER: hwActive = syncBQ[2] || syncBQ[3];
            default: hwActive = 1'b0;
        endcase
    end

    // Enable pin named by the ON slot code.
    assign hwEnPin = (r8OnSlot == ON_CODE_HW1) ? syncBQ[0] : syncBQ[1];

    // Regulator seven sleep steps; both flags drop when the sleep sequence ends.
    assign slotHitR7 = seqSleep && seqSlotStb && (seqSlotNum == lsr_sleep_slot(r7Slot));

    always_ff @(posedge clk_sys)
    begin
        if (!nrst || !seqSleep)
        begin
            r7SleepApply <= 1'b0;
            r7SleepOff <= 1'b0;
        end
        else if (slotHitR7)
        begin
            if (lsr_in_slots(r7Slot) && !r7HwEnAssign)
                r7SleepOff <= 1'b1;
            else
                r7SleepApply <= 1'b1;
        end
    end

    // Regulator eight enable state.
    always_comb
    begin
        r8StateD = r8StateQ;
        unique case (r8StateQ)
            R8_OFF:
            begin
                if (r8OnSlot == ON_CODE_HW1 || r8OnSlot == ON_CODE_HW2)
                    r8StateD = hwEnPin ? R8_ON : R8_OFF;
                else if (seqStartup && seqSlotStb && lsr_in_slots(r8OnSlot)
                    && seqSlotNum == r8OnSlot)
                    r8StateD = R8_ON;
            end
            R8_ON:
            begin
                if (uvEdge && uvAction == ACT_SHUT)
                    r8StateD = R8_TRIP;
                else if ((r8OnSlot == ON_CODE_HW1 || r8OnSlot == ON_CODE_HW2) && !hwEnPin)
                    r8StateD = R8_OFF;
                else if (r8SleepOff)
                    r8StateD = R8_OFF;
            end
            R8_TRIP:
            begin
                // A tripped regulator waits for a fresh start-up sequence.
                if (startRise)
                    r8StateD = R8_OFF;
            end
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            r8StateQ <= R8_OFF;
        else
            r8StateQ <= r8StateD;
    end

    // Hardware control may pick the sleep code; otherwise the ON code rules.
    assign r8CodeSel = (hwActive && r8CtrlQ[HVSEL_BIT])
        ? r8SleepVoltCode : r8OnQ[VSEL_MSB:0];

    lsr_volt_map u_r7_volt (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .code(r7SleepQ[VSEL_MSB:0]),
        .mv(r7MvComb)
    );

    lsr_volt_map u_r8_volt (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .code(r8CodeSel),
        .mv(r8MvComb)
    );

    // Registered controls to the regulators.
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            r7SleepLowPower <= RST_R7_SLEEP[MODE_BIT];
            r7SleepMv <= MV_BASE;
            r8VoltMv <= MV_BASE;
            r8Enable <= 1'b0;
            r8LowPower <= RST_R8_ON[MODE_BIT];
            r8Discharge <= 1'b0;
            r8SwitchMode <= 1'b0;
        end
        else
        begin
            r7SleepLowPower <= r7SleepQ[MODE_BIT];
            r7SleepMv <= r7MvComb;
            r8VoltMv <= r8MvComb;
            r8Enable <= (r8StateD == R8_ON) && !(hwActive && hwMode == HMODE_OFF);
            r8Discharge <= !((r8StateD == R8_ON) && !(hwActive && hwMode == HMODE_OFF))
                && !r8CtrlQ[FLT_BIT];
            if (hwActive && hwMode != HMODE_FOLLOW)
                r8LowPower <= 1'b1;
            else
                r8LowPower <= r8OnQ[MODE_BIT];
            r8SwitchMode <= r8CtrlQ[SWI_BIT];
        end
    end

    // Device reset is a one-cycle request to the reset controller.
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            devResetReq <= 1'b0;
        else
            devResetReq <= uvEdge && (uvAction == ACT_RESET);
    end

    // Sticky status, cleared by reading it; a new event beats the clear.
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            irqStatQ <= '0;
        else
            irqStatQ <= ((rdStb && regIdx == IDX_IRQ_STAT) ? '0 : irqStatQ)
                | {r8StateD == R8_TRIP && r8StateQ != R8_TRIP, uvEdge};
    end

    assign irq = |(irqStatQ & irqMaskQ);

    chk_sleep_default_slot:
        assert property (@(posedge clk_sys) disable iff (!nrst)
            (slotHitR7 && r7Slot == 3'h0 && seqSlotNum == 3'h5) |=> r7SleepApply)
        else $error("Default sleep slot did not apply sleep settings in slot five.");

    chk_sleep_disable_slot:
        assert property (@(posedge clk_sys) disable iff (!nrst)
            (seqSleep && seqSlotStb && r7Slot == 3'h4 && seqSlotNum == 3'h2
                && !r7HwEnAssign) |=> r7SleepOff)
        else $error("Code 100 did not disable regulator seven in slot two.");

    chk_sleep_late_slot:
        assert property (@(posedge clk_sys) disable iff (!nrst)
            (seqSleep && seqSlotStb && r7Slot == 3'h7 && seqSlotNum == 3'h1
                && !r7SleepOff) |=> (r7SleepApply && !r7SleepOff))
        else $error("Code 111 did not apply sleep settings in slot one.");

    chk_hw_assign_sleep:
        assert property (@(posedge clk_sys) disable iff (!nrst)
            (slotHitR7 && r7HwEnAssign && !r7SleepOff) |=> !r7SleepOff)
        else $error("Hardware-assigned regulator seven was disabled in sleep.");

    chk_sleep_mode_reset:
        assert property (@(posedge clk_sys) disable iff (!nrst)
            $rose(nrst) |-> ##1 r7SleepLowPower)
        else $error("Sleep mode did not reset to low power.");

    chk_uv_action_path:
        assert property (@(posedge clk_sys) disable iff (!nrst)
            (uvEdge && uvAction == 2'h2) |=> devResetReq ##1 !devResetReq)
        else $error("Undervoltage reset action gave no single-cycle request.");

    chk_uv_irq_always:
        assert property (@(posedge clk_sys) disable iff (!nrst)
            uvEdge |=> irqStatQ[0])
        else $error("Undervoltage event did not set its status bit.");

    chk_hw_volt_choice:
        assert property (@(posedge clk_sys) disable iff (!nrst)
            (hwActive && r8CtrlQ[10]) |-> (r8CodeSel == r8SleepVoltCode))
        else $error("Hardware control did not pick the sleep voltage code.");

    chk_hw_mode_off:
        assert property (@(posedge clk_sys) disable iff (!nrst)
            (hwActive && hwMode == 2'h1) |=> !r8Enable)
        else $error("Hardware off mode left regulator eight enabled.");

    chk_float_discharge:
        assert property (@(posedge clk_sys) disable iff (!nrst)
            (r8Discharge |-> !r8Enable && !$past(r8CtrlQ[7])) and (r8Enable |-> !r8Discharge))
        else $error("Discharge disagrees with enable or float bit.");

    chk_startup_enable:
        assert property (@(posedge clk_sys) disable iff (!nrst)
            (r8StateQ == R8_OFF && seqStartup && seqSlotStb && r8OnSlot == 3'h3
                && seqSlotNum == 3'h3) |=> (r8StateQ == R8_ON))
        else $error("Regulator eight missed its start-up slot.");

    chk_hw_enable_pin:
        assert property (@(posedge clk_sys) disable iff (!nrst)
            (r8OnSlot == 3'h6 && r8StateQ == R8_OFF && syncBQ[0]) |=> (r8StateQ == R8_ON))
        else $error("Hardware enable one did not turn regulator eight on.");

endmodule : lsr_regs
`default_nettype wire

// >>> lsr_seq_model.sv
`timescale 1ns/100ps
`default_nettype none
module lsr_seq_model
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic nrst,
    // Run request, sleep run when sleepRun is high.
    input wire logic go,
    input wire logic sleepRun,
    // Sequencer outputs.
    output logic seqStartup,
    output logic seqSleep,
    output logic seqSlotStb,
    output logic [2:0] seqSlotNum
);
    logic [4:0] cnt_q;
    logic run_q;
    logic mode_q;
    logic [2:0] slot;

    // Five slots four cycles apart, so each answer lands before the next slot.
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            run_q <= 1'b0;
            cnt_q <= 5'h00;
            mode_q <= 1'b0;
        end
        else if (go)
        begin
            run_q <= 1'b1;
            cnt_q <= 5'h00;
            mode_q <= sleepRun;
        end
        else if (run_q)
        begin
            cnt_q <= cnt_q + 5'h01;
            run_q <= (cnt_q != 5'h17);
        end
    end

    // The slot number is only valid with the strobe; it churns otherwise.
    assign slot = cnt_q[4:2] + 3'h1;
    assign seqSlotStb = run_q && (cnt_q[1:0] == 2'h1) && (cnt_q < 5'h14);
    assign seqSlotNum = seqSlotStb ? slot : ~slot;
    assign seqSleep = run_q && mode_q;
    assign seqStartup = run_q && !mode_q;
endmodule : lsr_seq_model
`default_nettype wire

// >>> tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, x) begin checked++; if ((g) !== (x)) begin errCount++; \
    $display("wrong value at %0t: got %0h want %0h", $time, g, x); end end
module tb
    import lsr_pkg::*;
;
    logic clk_sys, nrst, psel, penable, pwrite, go, sleepRun, pready, pslverr, e;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, q;
    logic seqStartup, seqSleep, seqSlotStb, r7HwEnAssign, r8SleepOff, rstSeen;
    logic [2:0] seqSlotNum, lastSlot, applySlot, offSlot, enSlot;
    logic [4:0] r8SleepVoltCode;
    logic hwEnable1, hwEnable2, hwControl1, hwControl2, r8Undervolt;
    logic r7SleepApply, r7SleepOff, r7SleepLowPower, r8Enable, r8LowPower;
    logic r8Discharge, r8SwitchMode, devResetReq, irq;
    logic [11:0] r7SleepMv, r8VoltMv;
    int errCount, checked;

    lsr_regs u_dut (.clk_sys, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .seqStartup, .seqSleep, .seqSlotStb, .seqSlotNum, .r7HwEnAssign,
        .r8SleepOff, .r8SleepVoltCode, .hwEnable1, .hwEnable2, .hwControl1, .hwControl2,
        .r8Undervolt, .r7SleepApply, .r7SleepOff, .r7SleepLowPower, .r7SleepMv, .r8Enable,
        .r8LowPower, .r8Discharge, .r8SwitchMode, .r8VoltMv, .devResetReq, .irq);
    lsr_seq_model u_seq (.clk_sys, .nrst, .go, .sleepRun, .seqStartup, .seqSleep,
        .seqSlotStb, .seqSlotNum);

    // Free-running system clock.
    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // Notes the slot in which each answer first shows, since flags drop after a run.
    always @(posedge clk_sys)
    begin
        if (seqSlotStb) lastSlot <= seqSlotNum;
        if (r7SleepApply && applySlot == 3'h0) applySlot <= lastSlot;
        if (r7SleepOff && offSlot == 3'h0) offSlot <= lastSlot;
        if (r8Enable && enSlot == 3'h0) enSlot <= lastSlot;
        if (devResetReq) rstSeen <= 1'b1;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc

    // One APB transfer; the request is held until pready is seen high.
    task automatic apb(input logic wr, input logic [IDX_W-1:0] idx, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees pready.
        do @(posedge clk_sys); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic runSeq(input logic s);
        @(posedge clk_sys);
        go <= 1'b1;
        sleepRun <= s;
        applySlot <= 3'h0;
        offSlot <= 3'h0;
        enSlot <= 3'h0;
        @(posedge clk_sys);
        go <= 1'b0;
        cyc(26);
    endtask : runSeq

    task automatic testRegs();
        logic [15:0] ix[3] = '{IDX_R7_SLEEP, IDX_R8_CTRL, IDX_R8_ON};
        logic [31:0] rv[3] = '{32'h0100, 32'h0200, 32'h0000};
        logic [31:0] mk[3] = '{32'he11f, 32'hdfc0, 32'he11f};
        `CHK(r7SleepLowPower, 1'b1)
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b0, ix[i], 32'h0);
            `CHK(q, rv[i])
            apb(1'b1, ix[i], 32'hffff_ffff);
            apb(1'b0, ix[i], 32'h0);
            `CHK(q, mk[i])
            apb(1'b1, ix[i], rv[i]);
        end
        apb(1'b0, 16'h4080, 32'h0);
        `CHK(e, 1'b1)
        $display("register test done");
    endtask : testRegs

    task automatic testVolt();
        logic [4:0] cd[4] = '{5'h00, 5'h0c, 5'h0d, 5'h1f};
        logic [11:0] mv[4] = '{12'h3e8, 12'h640, 12'h6a4, 12'hdac};
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, IDX_R7_SLEEP, {27'h0, cd[i]});
            apb(1'b1, IDX_R8_ON, {27'h0, cd[i]});
            cyc(2);
            `CHK(r7SleepMv, mv[i])
            `CHK(r8VoltMv, mv[i])
            `CHK(r7SleepLowPower, 1'b0)
        end
        $display("voltage test done");
    endtask : testVolt

    task automatic testSleep();
        logic [2:0] ap[9] = '{3'h5, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h3, 3'h1, 3'h4};
        for (int c = 0; c < 9; c++)
        begin
            r7HwEnAssign <= (c == 8);
            apb(1'b1, IDX_R7_SLEEP, {16'h0, (c == 8) ? 3'h2 : 3'(c), 13'h0});
            runSeq(1'b1);
            `CHK(applySlot, ap[c])
            `CHK(offSlot, (c >= 1 && c <= 5) ? 3'(6 - c) : 3'h0)
        end
        r7HwEnAssign <= 1'b0;
        $display("sleep slot test done");
    endtask : testSleep

    task automatic testOn();
        for (int c = 0; c < 6; c++)
        begin
            apb(1'b1, IDX_R8_ON, {16'h0, 3'(c), 13'h0});
            runSeq(1'b0);
            `CHK(enSlot, 3'(c))
            r8SleepOff <= 1'b1;
            cyc(2);
            r8SleepOff <= 1'b0;
            cyc(3);
            `CHK(r8Discharge, 1'b1)
        end
        apb(1'b1, IDX_R8_CTRL, 32'h0280);
        cyc(2);
        `CHK(r8Discharge, 1'b0)
        for (int c = 6; c < 8; c++)
        begin
            apb(1'b1, IDX_R8_ON, {16'h0, 3'(c), 13'h0});
            {hwEnable2, hwEnable1} <= (c == 6) ? 2'b10 : 2'b01;
            cyc(6);
            `CHK(r8Enable, 1'b0)
            {hwEnable2, hwEnable1} <= 2'b11;
            cyc(6);
            `CHK(r8Enable, 1'b1)
            {hwEnable2, hwEnable1} <= 2'b00;
            cyc(6);
        end
        $display("enable slot test done");
    endtask : testOn

    task automatic testUv();
        apb(1'b1, IDX_IRQ_MASK, 32'h3);
        for (int a = 0; a < 3; a++)
        begin
            apb(1'b1, IDX_R8_ON, 32'h2000);
            runSeq(1'b0);
            apb(1'b1, IDX_R8_CTRL, {16'h0, 2'(a), 14'h0200});
            rstSeen <= 1'b0;
            r8Undervolt <= 1'b1;
            cyc(3);
            r8Undervolt <= 1'b0;
            cyc(8);
            `CHK(irq, 1'b1)
            `CHK(r8Enable, a != 1)
            `CHK(rstSeen, a == 2)
            apb(1'b0, IDX_IRQ_STAT, 32'h0);
            `CHK(q, (a == 1) ? 32'h3 : 32'h1)
            cyc(1);
            `CHK(irq, 1'b0)
        end
        $display("undervoltage test done");
    endtask : testUv

    task automatic testHw();
        apb(1'b1, IDX_R8_ON, 32'h200d);
        apb(1'b1, IDX_R8_CTRL, 32'h0f00);
        r8SleepVoltCode <= 5'h1f;
        hwControl2 <= 1'b1;
        cyc(6);
        `CHK(r8VoltMv, 12'h6a4)
        apb(1'b1, IDX_R8_CTRL, 32'h1700);
        cyc(2);
        `CHK(r8VoltMv, 12'hdac)
        apb(1'b1, IDX_R8_CTRL, 32'h1f40);
        cyc(6);
        `CHK(r8VoltMv, 12'hdac)
        `CHK(r8SwitchMode, 1'b1)
        `CHK(r8LowPower, 1'b0)
        apb(1'b1, IDX_R8_ON, 32'h210d);
        cyc(2);
        `CHK(r8LowPower, 1'b1)
        apb(1'b1, IDX_R8_ON, 32'h200d);
        apb(1'b1, IDX_R8_CTRL, 32'h1800);
        cyc(2);
        `CHK(r8LowPower, 1'b1)
        `CHK(r8VoltMv, 12'h6a4)
        apb(1'b1, IDX_R8_CTRL, 32'h1900);
        cyc(3);
        `CHK(r8Enable, 1'b0)
        $display("hardware control test done");
    endtask : testHw

    task automatic stopTest();
        $display("comparisons %0d, mismatches %0d", checked, errCount);
        if (errCount == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stopTest

    // Main sequence: reset for 16 cycles, then every scenario in turn.
    initial
    begin
        {nrst, psel, penable, pwrite, go, sleepRun, r7HwEnAssign, r8SleepOff} = '0;
        {hwEnable1, hwEnable2, hwControl1, hwControl2, r8Undervolt, rstSeen} = '0;
        {paddr, pwdata, r8SleepVoltCode, lastSlot, applySlot, offSlot, enSlot} = '0;
        cyc(16);
        nrst <= 1'b1;
        testRegs();
        testVolt();
        testSleep();
        testOn();
        testUv();
        testHw();
        stopTest();
    end

    // Watchdog well beyond the roughly 820 cycles the scenarios need.
    initial
    begin
        #400000;
        errCount++;
        stopTest();
    end
endmodule : tb
`default_nettype wire
